// [txcmd_pkg.sv]
package txcmd_pkg;
  // Transmit standard codes
  localparam logic [3:0] STD_DISABLED = 4'h0;
  localparam logic [3:0] STD_V22BIS = 4'h1;
  localparam logic [3:0] STD_V22 = 4'h2;
  localparam logic [3:0] STD_B212 = 4'h3;
  localparam logic [3:0] STD_V23 = 4'h4;
  localparam logic [3:0] STD_V21 = 4'h5;
  localparam logic [3:0] STD_B103 = 4'h6;
  localparam logic [3:0] STD_TONE = 4'h7;
  // Field positions
  localparam int MODE_LSB = 0;
  localparam int GUARD_LSB = 4;
  localparam int ANSORIG_BIT = 7;
  localparam int ATTEN_LSB = 0;
  localparam int SCRAM_BIT = 5;
  localparam int BREAK_BIT = 6;
  localparam int RATE_BIT = 7;
  localparam int KIND_BIT = 0;
  localparam int DATA_LSB = 1;
  localparam int TXOFF_BIT = 7;
  // Attenuation limit and reset value, and the ones-run limit
  localparam logic [4:0] ATTEN_MAX = 5'h17;
  localparam logic [4:0] ATTEN_RESET = 5'h1F;
  localparam logic [6:0] RUN_LIMIT = 7'h40;
  // Guard tone codes
  localparam logic [1:0] GUARD_NONE = 2'h0;
  localparam logic [1:0] GUARD_550 = 2'h1;
  localparam logic [1:0] GUARD_1800 = 2'h3;
  // Symbol widths
  localparam logic [2:0] SYM_QUAD = 3'h4;
  localparam logic [2:0] SYM_DI = 3'h2;
  localparam logic [2:0] SYM_ONE = 3'h1;
  localparam logic [2:0] SYM_FSK = 3'h6;
  // Byte index in the mailbox
  localparam logic [1:0] IDX_MODE = 2'h0;
  localparam logic [1:0] IDX_PARAM = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
endpackage

// [txcmd_if.sv]
`timescale 1ns/1ps
interface txcmd_if;
  logic wr;
  logic [1:0] idx;
  logic [7:0] wdata;
  logic word_done;
  modport ctrl (output wr, output idx, output wdata, input word_done);
  modport dev (input wr, input idx, input wdata, output word_done);
endinterface

// [tx_cmd_dev.sv]
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module tx_cmd_dev
  import txcmd_pkg::*;
(
  input wire MCLK,
  input wire NRST,
  txcmd_if.dev mb,
  output logic [3:0] TX_STANDARD,
  output logic TONE_MODE,
  output logic [1:0] GUARD_TONE,
  output logic ANSWER_ORIGINATE_SELECT,
  output logic TONE_LOW_SELECT,
  output logic SINGLE_TONE,
  output logic [3:0] TONE_PAIR,
  output logic [4:0] ATTENUATION,
  output logic TX_MUTE,
  output logic RATE_600,
  output logic [2:0] SYMBOL_BITS,
  output logic [3:0] SYMBOL_DATA,
  output logic SYMBOL_STROBE,
  output logic TX_BIT,
  output logic TX_BIT_VALID,
  output logic WORD_REJECT
);
  typedef struct packed {
    logic [7:0] mode_stage;
    logic [7:0] param_stage;
    logic [2:0] have;
    logic [7:0] mode;
    logic [7:0] param;
    logic [7:0] data;
    logic [16:0] scr;
    logic [6:0] ones;
    logic [5:0] fsk;
    logic [2:0] fsk_left;
    logic [3:0] sym;
    logic sym_stb;
    logic tbit;
    logic tbit_vld;
    logic reject;
    logic done;
  } state_t;

  state_t cur;
  state_t nxt;

  // Word validity: transmit kind, no reserved codes or bits
  function automatic logic word_ok(input logic [7:0] m, input logic [7:0] d);
    logic ok;
    ok = (d[KIND_BIT] == 1'b0);
    ok = ok && (m[3:0] <= STD_TONE);
    ok = ok && (m[5:4] != 2'h2);
    ok = ok && (m[6] == 1'b0);
    return ok;
  endfunction

  // One scrambler and ones-run breaker step, returns {bit, new state}
  function automatic logic [24:0] scram_step(input logic din, input logic [16:0] sr,
      input logic [6:0] run, input logic [7:0] p);
    logic b;
    logic o;
    logic [16:0] s;
    logic [6:0] r;
    b = din;
    if (p[BREAK_BIT] && run >= RUN_LIMIT) begin
      b = ~b;
    end
    if (p[SCRAM_BIT]) begin
      o = b ^ sr[13] ^ sr[16];
    end else begin
      o = b;
    end
    s = {sr[15:0], o};
    if (!o) begin
      r = 7'h0;
    end else if (run >= RUN_LIMIT) begin
      r = 7'h1;
    end else begin
      r = run + 7'h1;
    end
    return {o, s, r};
  endfunction

  // Next state
  always_comb begin
    logic [24:0] st;
    logic [2:0] n;
    st = '0;
    n = '0;
    nxt = cur;
    nxt.sym_stb = 1'b0;
    nxt.tbit_vld = 1'b0;
    nxt.done = 1'b0;
    // Drain one FSK sample per cycle, bit 1 first
    if (cur.fsk_left != 3'h0) begin
      nxt.tbit = cur.fsk[0];
      nxt.tbit_vld = 1'b1;
      nxt.fsk = {1'b0, cur.fsk[5:1]};
      nxt.fsk_left = cur.fsk_left - 3'h1;
    end
    // Collect bytes of the exchange
    if (mb.wr) begin
      unique case (mb.idx)
        IDX_MODE: begin
          nxt.mode_stage = mb.wdata;
          nxt.have = 3'h1;
        end
        IDX_PARAM: begin
          nxt.param_stage = mb.wdata;
          nxt.have = cur.have | 3'h2;
        end
        IDX_DATA: begin
          nxt.have = 3'h0;
          nxt.done = 1'b1;
          if (cur.have == 3'h3 && word_ok(cur.mode_stage, mb.wdata)) begin
            nxt.mode = cur.mode_stage;
            nxt.param = cur.param_stage;
            nxt.data = mb.wdata;
            nxt.reject = 1'b0;
            if (!mb.wdata[TXOFF_BIT]) begin
              unique case (cur.mode_stage[3:0])
                STD_V22BIS, STD_V22, STD_B212: begin
                  // One symbol per exchange
                  nxt.sym_stb = 1'b1;
                  n = (cur.mode_stage[3:0] == STD_V22BIS) ? SYM_QUAD :
                      (cur.mode_stage[3:0] == STD_V22 && cur.param_stage[RATE_BIT]) ? SYM_ONE : SYM_DI;
                  for (int i = 0; i < 4; i++) begin
                    st = scram_step(mb.wdata[DATA_LSB + i], nxt.scr, nxt.ones, cur.param_stage);
                    nxt.sym[i] = (i < int'(n)) ? st[24] : 1'b0;
                    if (i < int'(n)) begin
                      nxt.scr = st[23:7];
                      nxt.ones = st[6:0];
                    end
                  end
                end
                STD_V23, STD_V21, STD_B103: begin
                  nxt.fsk = mb.wdata[6:1];
                  nxt.fsk_left = SYM_FSK;
                end
                default: begin
                end
              endcase
            end
          end else begin
            nxt.reject = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      cur <= '0;
      cur.param <= {3'h0, ATTEN_RESET};
      cur.data <= 8'h80;
    end else begin
      cur <= nxt;
    end
  end

  // Outputs decoded from the applied word, with the WORD_REJECT and word_done flags
  logic tone;
  assign tone = (cur.mode[3:0] == STD_TONE);
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      TX_STANDARD <= STD_DISABLED;
      TONE_MODE <= 1'b0;
      GUARD_TONE <= GUARD_NONE;
      ANSWER_ORIGINATE_SELECT <= 1'b0;
      TONE_LOW_SELECT <= 1'b0;
      SINGLE_TONE <= 1'b0;
      TONE_PAIR <= 4'h0;
      ATTENUATION <= ATTEN_RESET;
      TX_MUTE <= 1'b1;
      RATE_600 <= 1'b0;
      SYMBOL_BITS <= 3'h0;
      SYMBOL_DATA <= 4'h0;
      SYMBOL_STROBE <= 1'b0;
      TX_BIT <= 1'b0;
      TX_BIT_VALID <= 1'b0;
      WORD_REJECT <= 1'b0;
      mb.word_done <= 1'b0;
    end else begin
      TX_STANDARD <= cur.mode[3:0];
      TONE_MODE <= tone;
      GUARD_TONE <= tone ? GUARD_NONE : cur.mode[5:4];
      ANSWER_ORIGINATE_SELECT <= !tone && cur.mode[ANSORIG_BIT];
      TONE_LOW_SELECT <= tone && cur.param[RATE_BIT] && cur.mode[ANSORIG_BIT];
      SINGLE_TONE <= tone && cur.param[RATE_BIT];
      TONE_PAIR <= tone ? cur.data[4:1] : 4'h0;
      ATTENUATION <= cur.param[4:0];
      TX_MUTE <= (cur.param[4:0] > ATTEN_MAX) || cur.data[TXOFF_BIT] ||
                 (cur.mode[3:0] == STD_DISABLED);
      RATE_600 <= !tone && cur.param[RATE_BIT];
      SYMBOL_BITS <= (cur.mode[3:0] == STD_V22BIS) ? SYM_QUAD :
                     (cur.mode[3:0] == STD_V22 && cur.param[RATE_BIT]) ? SYM_ONE :
                     (cur.mode[3:0] == STD_V22 || cur.mode[3:0] == STD_B212) ? SYM_DI : 3'h0;
      SYMBOL_DATA <= cur.sym;
      SYMBOL_STROBE <= cur.sym_stb;
      TX_BIT <= cur.tbit;
      TX_BIT_VALID <= cur.tbit_vld;
      WORD_REJECT <= cur.reject;
      mb.word_done <= cur.done;
    end
  end
endmodule

// [tx_cmd_ctrl.sv]
`timescale 1ns/1ps
module tx_cmd_ctrl
  import txcmd_pkg::*;
(
  input wire MCLK,
  input wire NRST,
  txcmd_if.ctrl mb,
  input wire [7:0] MODE_BYTE,
  input wire [7:0] PARAM_BYTE,
  input wire [7:0] DATA_BYTE,
  input wire SEND,
  output logic BUSY,
  output logic DONE
);
  typedef enum logic [1:0] {IDLE, B1, B2, WAIT} phase_t;
  typedef struct packed {
    phase_t ph;
    logic [7:0] p;
    logic [7:0] d;
    logic wr;
    logic [1:0] idx;
    logic [7:0] wdata;
    logic done;
  } state_t;

  state_t cur;
  state_t nxt;

  // Writes the three bytes back to back, reserved bits forced clear
  always_comb begin
    nxt = cur;
    nxt.wr = 1'b0;
    nxt.done = 1'b0;
    unique case (cur.ph)
      IDLE: begin
        if (SEND) begin
          nxt.wr = 1'b1;
          nxt.idx = IDX_MODE;
          nxt.wdata = {MODE_BYTE[7], 1'b0, MODE_BYTE[5:0]};
          nxt.p = PARAM_BYTE;
          nxt.d = {DATA_BYTE[7:1], 1'b0};
          nxt.ph = B1;
        end
      end
      B1: begin
        nxt.wr = 1'b1;
        nxt.idx = IDX_PARAM;
        nxt.wdata = cur.p;
        nxt.ph = B2;
      end
      B2: begin
        nxt.wr = 1'b1;
        nxt.idx = IDX_DATA;
        nxt.wdata = cur.d;
        nxt.ph = WAIT;
      end
      WAIT: begin
        if (mb.word_done) begin
          nxt.done = 1'b1;
          nxt.ph = IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign mb.wr = cur.wr;
  assign mb.idx = cur.idx;
  assign mb.wdata = cur.wdata;

  // Status outputs
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      BUSY <= 1'b0;
      DONE <= 1'b0;
    end else begin
      BUSY <= (nxt.ph != IDLE);
      DONE <= cur.done;
    end
  end
endmodule

// [txcmd_props.sv]
`timescale 1ns/1ps
module txcmd_props
  import txcmd_pkg::*;
(
  input wire MCLK,
  input wire NRST,
  input logic wr,
  input logic [1:0] idx,
  input logic [7:0] wdata,
  input logic word_done
);
  // All checks sample on the one clock
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  chk_done_after_data: assert property (wr && idx == IDX_DATA && $past(wr && idx == IDX_PARAM) |-> ##2 word_done)
    else $error("word done missing");
  chk_done_cause: assert property (word_done |-> $past(wr && idx == IDX_DATA, 2))
    else $error("word done without data byte");
  chk_done_single: assert property (word_done |=> !word_done)
    else $error("word done too long");
  chk_word_order: assert property (wr && idx == IDX_MODE |=> wr && idx == IDX_PARAM ##1 wr && idx == IDX_DATA)
    else $error("bytes out of order");
  chk_param_after_mode: assert property (wr && idx == IDX_PARAM |-> $past(wr && idx == IDX_MODE))
    else $error("parameter byte alone");
  chk_kind_bit: assert property (wr && idx == IDX_DATA |-> !wdata[KIND_BIT])
    else $error("kind bit set");
  chk_reserved_bit: assert property (wr && idx == IDX_MODE |-> !wdata[6])
    else $error("reserved bit set");
  chk_guard_code: assert property (wr && idx == IDX_MODE |-> wdata[5:4] != 2'h2)
    else $error("reserved guard code");
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import txcmd_pkg::*;
;
  logic mclk, nrst, busy, done, tone, ao, tlow, single, mute, r600, sstb, tbit, tval, rej, rej2;
  logic send = 1'b0;
  logic [7:0] mb = 8'h00, pb = 8'h00, db = 8'h00;
  logic [3:0] stdsel, pair, sdata;
  logic [3:0] sym = 4'h0;
  logic [1:0] grd;
  logic [4:0] att;
  logic [2:0] sbits;
  logic [5:0] fsk = 6'h00;
  int nfsk = 0, num_errors = 0, samples_checked = 0;
  txcmd_if m1();
  txcmd_if m2();
  tx_cmd_ctrl tx_cmd_ctrl_inst (.MCLK(mclk), .NRST(nrst), .mb(m1.ctrl), .MODE_BYTE(mb), .PARAM_BYTE(pb),
    .DATA_BYTE(db), .SEND(send), .BUSY(busy), .DONE(done));
  tx_cmd_dev tx_cmd_dev_inst (.MCLK(mclk), .NRST(nrst), .mb(m1.dev), .TX_STANDARD(stdsel), .TONE_MODE(tone),
    .GUARD_TONE(grd), .ANSWER_ORIGINATE_SELECT(ao), .TONE_LOW_SELECT(tlow), .SINGLE_TONE(single),
    .TONE_PAIR(pair), .ATTENUATION(att), .TX_MUTE(mute), .RATE_600(r600), .SYMBOL_BITS(sbits),
    .SYMBOL_DATA(sdata), .SYMBOL_STROBE(sstb), .TX_BIT(tbit), .TX_BIT_VALID(tval), .WORD_REJECT(rej));
  // Second device fed directly by the bench with faulty words
  tx_cmd_dev tx_cmd_dev_inst2 (.MCLK(mclk), .NRST(nrst), .mb(m2.dev), .TX_STANDARD(), .TONE_MODE(),
    .GUARD_TONE(), .ANSWER_ORIGINATE_SELECT(), .TONE_LOW_SELECT(), .SINGLE_TONE(), .TONE_PAIR(),
    .ATTENUATION(), .TX_MUTE(), .RATE_600(), .SYMBOL_BITS(), .SYMBOL_DATA(), .SYMBOL_STROBE(), .TX_BIT(),
    .TX_BIT_VALID(), .WORD_REJECT(rej2));
  txcmd_props txcmd_props_inst (.MCLK(mclk), .NRST(nrst), .wr(m1.wr), .idx(m1.idx), .wdata(m1.wdata),
    .word_done(m1.word_done));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Collect serial samples and symbols
  always @(posedge mclk) begin
    if (tval === 1'b1) begin
      fsk <= {tbit, fsk[5:1]};
      nfsk <= nfsk + 1;
    end
    if (sstb === 1'b1) begin
      sym <= sdata;
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One whole word through the controller
  task automatic word(input logic [7:0] m, input logic [7:0] p, input logic [7:0] d);
    int n;
    @(posedge mclk);
    mb <= m;
    pb <= p;
    db <= d;
    send <= 1'b1;
    nfsk = 0;
    @(posedge mclk);
    send <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
      if (n == 1) begin
        chk("busy", 8'h01, busy);
      end
    end
    // SEND is taken one edge before the loop; DONE is seen seven edges on
    chk("cycles", 8'h07, n[7:0]);
    chk("busy", 8'h00, busy);
    repeat (6) @(posedge mclk);
  endtask
  task automatic w2(input logic [1:0] i, input logic [7:0] v);
    @(posedge mclk);
    m2.wr <= 1'b1;
    m2.idx <= i;
    m2.wdata <= v;
    @(posedge mclk);
    m2.wr <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task automatic w3(input logic [7:0] m, input logic [7:0] p, input logic [7:0] d);
    w2(IDX_MODE, m);
    w2(IDX_PARAM, p);
    w2(IDX_DATA, d);
  endtask
  task automatic t_reset();
    chk("att", 8'h1F, att);
    chk("mute", 8'h01, mute);
    word(8'h02, 8'h00, 8'h00);
    chk("mute", 8'h00, mute);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("att", 8'h1F, att);
    chk("mute", 8'h01, mute);
    nrst <= 1'b1;
  endtask
  task automatic t_modes();
    for (int s = 0; s < 8; s++) begin
      word({4'h0, s[3:0]}, 8'h17, 8'h00);
      chk("std", {4'h0, s[3:0]}, stdsel);
      chk("tone", {7'h00, s == 7}, tone);
      chk("mute", {7'h00, s == 0}, mute);
      chk("att", 8'h17, att);
      chk("rej", 8'h00, rej);
    end
  endtask
  task automatic t_atten();
    word(8'h02, 8'h18, 8'h00);
    chk("mute", 8'h01, mute);
    chk("att", 8'h18, att);
    word(8'h02, 8'h00, 8'h80);
    chk("mute", 8'h01, mute);
    chk("att", 8'h00, att);
  endtask
  task automatic t_fields();
    word(8'h92, 8'h80, 8'h02);
    chk("guard", 8'h01, grd);
    chk("orig", 8'h01, ao);
    chk("rate", 8'h01, r600);
    chk("width", 8'h01, sbits);
    chk("sym", 8'h01, sym);
    word(8'h33, 8'h00, 8'h14);
    chk("guard", 8'h03, grd);
    chk("orig", 8'h00, ao);
    chk("sym", 8'h02, sym);
    word(8'h01, 8'h00, 8'h14);
    chk("width", 8'h04, sbits);
    chk("sym", 8'h0A, sym);
  endtask
  // Scrambler from a cleared state: 14 bits pass, then bit 14 takes bit 0 in
  task automatic t_scram();
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    word(8'h01, 8'h20, 8'h02);
    chk("sym", 8'h01, sym);
    repeat (3) word(8'h01, 8'h20, 8'h02);
    chk("sym", 8'h05, sym);
  endtask
  // 16 symbols of four ones, then the 17th first bit flips if enabled
  task automatic t_breaker();
    for (int b = 0; b < 2; b++) begin
      word(8'h01, 8'h00, 8'h00);
      for (int k = 0; k < 17; k++) word(8'h01, {1'b0, b[0], 6'h00}, 8'h1E);
      chk("sym", b ? 8'h0E : 8'h0F, sym);
    end
  endtask
  task automatic t_tone();
    word(8'h87, 8'h80, 8'h0A);
    chk("single", 8'h01, single);
    chk("low", 8'h01, tlow);
    chk("pair", 8'h05, pair);
    chk("orig", 8'h00, ao);
    chk("rate", 8'h00, r600);
    word(8'h07, 8'h80, 8'h00);
    chk("low", 8'h00, tlow);
    word(8'h07, 8'h00, 8'h1E);
    chk("single", 8'h00, single);
    chk("pair", 8'h0F, pair);
  endtask
  task automatic t_fsk();
    word(8'h05, 8'h00, 8'h58);
    chk("count", {5'h00, SYM_FSK}, nfsk[7:0]);
    chk("stream", 8'h2C, {2'h0, fsk});
  endtask
  // Each refused word but the second (mode 8'h42) follows a good word or reset, so the level must move
  task automatic t_faults();
    w3(8'h02, 8'h00, 8'h01);
    chk("rej", 8'h01, rej2);
    w3(8'h42, 8'h00, 8'h00);
    chk("rej", 8'h01, rej2);
    w3(8'h02, 8'h00, 8'h00);
    chk("rej", 8'h00, rej2);
    w3(8'h22, 8'h00, 8'h00);
    chk("rej", 8'h01, rej2);
    w3(8'h02, 8'h00, 8'h00);
    chk("rej", 8'h00, rej2);
    w3(8'h08, 8'h00, 8'h00);
    chk("rej", 8'h01, rej2);
    w3(8'h02, 8'h00, 8'h00);
    chk("rej", 8'h00, rej2);
    w2(IDX_DATA, 8'h00);
    chk("rej", 8'h01, rej2);
  endtask
  // Main sequence
  initial begin
    nrst = 1'b0;
    m2.wr = 1'b0;
    m2.idx = 2'h0;
    m2.wdata = 8'h00;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    t_reset();
    t_modes();
    t_atten();
    t_fields();
    t_scram();
    t_breaker();
    t_tone();
    t_fsk();
    t_faults();
    conclude();
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    conclude();
  end
endmodule
